// >>> shared/dmt_defs.vh
// Constants for the discrete input and move trigger logic.
// Assumes a 100 MHz system clock and APB register access with 32-bit data.
`ifndef DMT_DEFS_VH
`define DMT_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DMT_OFS_FUNC 12'h000
`define DMT_OFS_POL 12'h004
`define DMT_OFS_SCAN 12'h008
`define DMT_OFS_OUTCFG 12'h00C
`define DMT_OFS_STATUS 12'h010
`define DMT_OFS_HOME 12'h014

// ----------------------------------------------------------------
// Input function codes, three bits per input
// ----------------------------------------------------------------
`define DMT_FN_NONE 3'h0
`define DMT_FN_LIMIT 3'h1
`define DMT_FN_JOGP 3'h2
`define DMT_FN_JOGN 3'h3
`define DMT_FN_JOGSPD 3'h4
`define DMT_FN_KILL 3'h5
`define DMT_FN_MSEL 3'h6
`define DMT_FN_STOP 3'h7
`define DMT_FN_WBOOT 3'h0

// ----------------------------------------------------------------
// Output function codes and field positions
// ----------------------------------------------------------------
`define DMT_OUT_NONE 2'h0
`define DMT_OUT_BRAKE 2'h1
`define DMT_OUT_MOTION 2'h2
`define DMT_OUT_STALL 2'h3
`define DMT_OUTCFG_POL 2
`define DMT_FUNC_WB_BIT 12

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DMT_CLK_HZ 100000000
`define DMT_MS_CYCLES 17'd100000
`define DMT_SCAN_MAX_MS 15'd19656
// Tachometer window: 1 / 156.25 Hz = 6.4 ms.
`define DMT_TACH_US 6400
// Window in 10 ns cycles, sized to the tachometer counter width.
`define DMT_TACH_CYCLES 20'd640000
`define DMT_WB_MIN_US 500

// ----------------------------------------------------------------
// Motion command codes and rate codes
// ----------------------------------------------------------------
`define DMT_CMD_RUN 2'h0
`define DMT_CMD_STOP 2'h1
`define DMT_CMD_KILL 2'h2
`define DMT_RATE_JOG 1'b0
`define DMT_RATE_STOP 1'b1

`endif

// >>> core/dmt_core.v
// Discrete input function logic, move trigger and homing sequencer.
// Assumes level inputs synchronous to sys_clk, an APB master, and a
// profile engine that obeys the command, speed and direction outputs.
//
// How it works
// - Limit active during motion: stop at stop rate, latch direction.
// - After latch, jog and step input pass only in the opposite direction until limit input is released.
// - Held jog input: jog accel, low or high velocity per speed input.
// - No speed input configured means low jog velocity.
// - Speed input change during jog ramps to the new velocity.
// - Kill ends all motion at once, no ramp.
// - Stop ends all motion at the stop rate.
// - Move-select bits form a 3-bit code; zero idle, n runs move n.
// - Move select only on inputs 1 to 3, input 1 is LSB.
// - Bit weight fixed by input number even if others unused.
// - Move starts only after code stable for the scan time.
// - Scan time accepted from 0 to 19656 ms.
// - Warm reset and fault clear on warm-boot release edge.
// - Brake output follows any fault, with configurable polarity.
// - In-motion output during step pulses or a stored move.
// - No in-motion for step rates below 156.25 Hz.
// - Stall output follows the stall estimator.
// - Each input has its own polarity before function decode.
// - Homing searches at velocity sign until limit goes active.
// - Then reverses and creeps at one sixteenth until limit releases.
// - Then offset move opposite to search, then zero position.
// - Step and direction inputs discarded while a stored move runs.
`timescale 1ns/1ns
`default_nettype none
`include "dmt_defs.vh"

module dmt_core (
   input wire sys_clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [3:0] din,
   output reg dout,
   input wire step_in,
   input wire dir_in,
   input wire fault,
   input wire stall_open_loop_stall_estimator,
   input wire engine_busy,
   input wire engine_stopped,
   input wire move_done,
   output reg [1:0] motion_cmd,
   output reg motion_rate,
   output reg jog_run,
   output reg jog_dir,
   output reg jog_high,
   output reg move_start,
   output reg [2:0] move_num,
   output reg home_creep,
   output reg home_offset,
   output reg home_dir,
   output reg zero_pos,
   output reg step_out,
   output reg dir_out,
   output reg warm_reset
);

   // ----------------------------------------------------------------
   // Homing states
   // ----------------------------------------------------------------
   localparam HS_IDLE = 5'b00001;
   localparam HS_SEARCH = 5'b00010;
   localparam HS_BRAKE = 5'b00100;
   localparam HS_CREEP = 5'b01000;
   localparam HS_OFFSET = 5'b10000;

   reg [11:0] func_cfg;
   reg wb_en;
   reg [3:0] pol_cfg;
   reg [14:0] scan_ms;
   reg [1:0] out_fn;
   reg out_pol;
   reg [6:0] home_mask;
   reg [3:0] act;
   reg [3:0] act_d;
   reg [2:0] code_d;
   reg [14:0] ms_left;
   reg [16:0] ms_div;
   reg armed;
   reg [2:0] armed_code;
   reg lim_latched;
   reg lim_dir;
   reg stored_run;
   reg [4:0] hstate;
   reg step_d;
   reg [19:0] tach_cnt;
   reg tach_seen;
   reg in_motion;

   // Function-to-input match for one code, used by the decodes below except move select and warm boot.
   function has_fn;
      input [11:0] cfg;
      input [3:0] lvl;
      input [2:0] fn;
      integer k;
      begin
         has_fn = 1'b0;
         for (k = 0; k < 4; k = k + 1) begin
            if (cfg[k*3 +: 3] == fn && lvl[k])
               has_fn = 1'b1;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // Zero wait states; unmapped reads return zero without error.
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         func_cfg <= 12'h000;
         wb_en <= 1'b0;
         pol_cfg <= 4'hF;
         scan_ms <= 15'h0000;
         out_fn <= `DMT_OUT_NONE;
         out_pol <= 1'b0;
         home_mask <= 7'h00;
      end else if (psel && penable && pwrite) begin
         case (paddr)
            `DMT_OFS_FUNC: begin
               func_cfg <= pwdata[11:0];
               wb_en <= pwdata[`DMT_FUNC_WB_BIT];
            end
            `DMT_OFS_POL: pol_cfg <= pwdata[3:0];
            `DMT_OFS_SCAN: begin
               // Values past the limit clamp rather than wrap.
               if (pwdata[31:0] > {17'h00000, `DMT_SCAN_MAX_MS})
                  scan_ms <= `DMT_SCAN_MAX_MS;
               else
                  scan_ms <= pwdata[14:0];
            end
            `DMT_OFS_OUTCFG: begin
               out_fn <= pwdata[1:0];
               out_pol <= pwdata[`DMT_OUTCFG_POL];
            end
            `DMT_OFS_HOME: home_mask <= pwdata[6:0];
            default: ;
         endcase
      end
   end

   // Read mux; status shows the block's own state.
   always @* begin
      case (paddr)
         `DMT_OFS_FUNC: prdata = {19'h00000, wb_en, func_cfg};
         `DMT_OFS_POL: prdata = {28'h0000000, pol_cfg};
         `DMT_OFS_SCAN: prdata = {17'h00000, scan_ms};
         `DMT_OFS_OUTCFG: prdata = {29'h00000000, out_pol, out_fn};
         `DMT_OFS_STATUS: prdata = {15'h0000, hstate, stored_run, in_motion,
            lim_dir, lim_latched, armed_code, 1'b0, act};
         `DMT_OFS_HOME: prdata = {25'h0000000, home_mask};
         default: prdata = 32'h00000000;
      endcase
   end

   // ----------------------------------------------------------------
   // Input polarity and function decode
   // ----------------------------------------------------------------
   // Polarity bit 1 means active high.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         act <= 4'h0;
         act_d <= 4'h0;
      end else begin
         act <= ~(din ^ pol_cfg);
         act_d <= act;
      end
   end

   wire lim_on = has_fn(func_cfg, act, `DMT_FN_LIMIT);
   wire lim_was = has_fn(func_cfg, act_d, `DMT_FN_LIMIT);
   wire lim_fall = lim_was && !lim_on;
   wire jog_p = has_fn(func_cfg, act, `DMT_FN_JOGP);
   wire jog_n = has_fn(func_cfg, act, `DMT_FN_JOGN);
   wire spd = has_fn(func_cfg, act, `DMT_FN_JOGSPD);
   wire kill_on = has_fn(func_cfg, act, `DMT_FN_KILL);
   wire stop_on = has_fn(func_cfg, act, `DMT_FN_STOP);
   // Warm boot shares the input 4 slot when enabled.
   wire wb_on = wb_en && act[3];
   wire wb_was = wb_en && act_d[3];
   // Only inputs 1 to 3 may select moves; each keeps its own weight.
   wire [2:0] msel_code;
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_msel
         assign msel_code[g] = (func_cfg[g*3 +: 3] == `DMT_FN_MSEL) && act[g];
      end
   endgenerate

   wire moving = engine_busy || in_motion || stored_run;

   // ----------------------------------------------------------------
   // Move select debounce and launch
   // ----------------------------------------------------------------
   // Any code change reloads the timer; a launch disarms until the code
   // changes again, so a held code cannot retrigger.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         code_d <= 3'h0;
         ms_left <= 15'h0000;
         ms_div <= 17'h00000;
         armed <= 1'b0;
         armed_code <= 3'h0;
         move_start <= 1'b0;
         move_num <= 3'h0;
      end else begin
         move_start <= 1'b0;
         code_d <= msel_code;
         if (msel_code != code_d) begin
            ms_left <= scan_ms;
            ms_div <= 17'h00000;
            armed <= 1'b1;
            armed_code <= msel_code;
         end else if (armed) begin
            if (ms_left == 15'h0000) begin
               armed <= 1'b0;
               if (armed_code != 3'h0 && !kill_on && !stop_on) begin
                  move_start <= 1'b1;
                  move_num <= armed_code;
               end
            end else if (ms_div == `DMT_MS_CYCLES - 17'd1) begin
               ms_div <= 17'h00000;
               ms_left <= ms_left - 15'd1;
            end else begin
               ms_div <= ms_div + 17'd1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Travel limit latch and stored-move tracking
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lim_latched <= 1'b0;
         lim_dir <= 1'b0;
         stored_run <= 1'b0;
      end else begin
         if (lim_on && !lim_was && moving && hstate == HS_IDLE) begin
            lim_latched <= 1'b1;
            lim_dir <= jog_run ? jog_dir : dir_out;
         end else if (lim_fall) begin
            lim_latched <= 1'b0;
         end
         if (move_start)
            stored_run <= 1'b1;
         else if (move_done || kill_on || stop_on)
            stored_run <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Homing sequencer
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hstate <= HS_IDLE;
         home_creep <= 1'b0;
         home_offset <= 1'b0;
         home_dir <= 1'b0;
         zero_pos <= 1'b0;
      end else begin
         zero_pos <= 1'b0;
         if (kill_on || stop_on) begin
            hstate <= HS_IDLE;
            home_creep <= 1'b0;
            home_offset <= 1'b0;
         end else begin
            case (hstate)
               HS_IDLE: begin
                  if (move_start && home_mask[move_num - 3'd1])
                     hstate <= HS_SEARCH;
               end
               HS_SEARCH: begin
                  if (lim_on && !lim_was)
                     hstate <= HS_BRAKE;
               end
               HS_BRAKE: begin
                  if (engine_stopped) begin
                     hstate <= HS_CREEP;
                     home_creep <= 1'b1;
                     home_dir <= 1'b1;
                  end
               end
               HS_CREEP: begin
                  if (lim_fall) begin
                     hstate <= HS_OFFSET;
                     home_creep <= 1'b0;
                     home_offset <= 1'b1;
                  end
               end
               HS_OFFSET: begin
                  if (move_done) begin
                     hstate <= HS_IDLE;
                     home_offset <= 1'b0;
                     home_dir <= 1'b0;
                     zero_pos <= 1'b1;
                  end
               end
               default: hstate <= HS_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Motion command arbitration
   // ----------------------------------------------------------------
   // Kill outranks stop, which outranks a limit hit; jogging is vetoed
   // toward a latched limit so a trapped actuator can still back out.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         motion_cmd <= `DMT_CMD_RUN;
         motion_rate <= `DMT_RATE_JOG;
         jog_run <= 1'b0;
         jog_dir <= 1'b0;
         jog_high <= 1'b0;
         step_out <= 1'b0;
         dir_out <= 1'b0;
      end else begin
         jog_high <= spd;
         if (kill_on) begin
            motion_cmd <= `DMT_CMD_KILL;
            jog_run <= 1'b0;
         end else if (stop_on) begin
            motion_cmd <= `DMT_CMD_STOP;
            motion_rate <= `DMT_RATE_STOP;
            jog_run <= 1'b0;
         end else if (lim_on && !lim_was && moving && hstate != HS_CREEP) begin
            motion_cmd <= `DMT_CMD_STOP;
            motion_rate <= `DMT_RATE_STOP;
            jog_run <= 1'b0;
         end else begin
            motion_cmd <= `DMT_CMD_RUN;
            motion_rate <= `DMT_RATE_JOG;
            if (jog_p && !(lim_latched && !lim_dir)) begin
               jog_run <= 1'b1;
               jog_dir <= 1'b0;
            end else if (jog_n && !(lim_latched && lim_dir)) begin
               jog_run <= 1'b1;
               jog_dir <= 1'b1;
            end else begin
               jog_run <= 1'b0;
            end
         end
         // External steps pass only when no stored move owns the axis.
         if (!stored_run && !kill_on && !stop_on &&
               !(lim_latched && dir_in == lim_dir)) begin
            step_out <= step_in;
            dir_out <= dir_in;
         end else begin
            step_out <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Step tachometer and output function
   // ----------------------------------------------------------------
   // Two rising edges within 6.4 ms are needed, which is the 156.25 Hz
   // floor; a single stray pulse never shows as motion.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         step_d <= 1'b0;
         tach_cnt <= 20'h00000;
         tach_seen <= 1'b0;
         in_motion <= 1'b0;
         dout <= 1'b0;
         warm_reset <= 1'b0;
      end else begin
         step_d <= step_in;
         if (step_in && !step_d) begin
            tach_cnt <= 20'h00000;
            tach_seen <= 1'b1;
            in_motion <= tach_seen;
         end else if (tach_cnt == `DMT_TACH_CYCLES) begin
            tach_seen <= 1'b0;
            in_motion <= 1'b0;
         end else begin
            tach_cnt <= tach_cnt + 20'd1;
         end
         warm_reset <= wb_was && !wb_on;
         case (out_fn)
            `DMT_OUT_BRAKE: dout <= fault ^ ~out_pol;
            `DMT_OUT_MOTION: dout <= (in_motion || stored_run) ^ ~out_pol;
            `DMT_OUT_STALL: dout <= stall_open_loop_stall_estimator ^ ~out_pol;
            default: dout <= ~out_pol;
         endcase
      end
   end

endmodule
`default_nettype wire

// >>> bench/dmt_checker_properties.sv
// Concurrent checks on the ports of the move trigger block.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module dmt_checker (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [3:0] din,
   input wire logic [1:0] motion_cmd,
   input wire logic motion_rate,
   input wire logic jog_run,
   input wire logic move_start,
   input wire logic [2:0] move_num,
   input wire logic home_creep,
   input wire logic home_offset,
   input wire logic home_dir,
   input wire logic zero_pos,
   input wire logic step_out,
   input wire logic warm_reset
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------------
   // Launch, rate, homing and warm reset relations
   // ----------------------------------------------------------------
   // A held code must not relaunch, so the strobe is never two cycles long.
   chk_launch_once: assert property (move_start |=> !move_start)
      else $error("move start lasted more than one cycle");
   chk_move_code: assert property (move_start |-> move_num != 3'h0)
      else $error("launch with idle code");
   chk_stop_rate: assert property (motion_cmd == 2'h1 |-> motion_rate)
      else $error("stop without stop rate");
   chk_jog_rate: assert property (jog_run && motion_cmd == 2'h0 |-> !motion_rate)
      else $error("jog not at jog rate");
   chk_creep_back: assert property (home_creep |-> home_dir)
      else $error("creep not reversed");
   chk_offset_back: assert property (home_offset |-> home_dir && !home_creep)
      else $error("offset move direction wrong");
   chk_zero_arrive: assert property (zero_pos |-> $past(home_offset))
      else $error("position zeroed outside offset move");
   // An edge of either direction on din[3] must lie a few cycles back.
   chk_warm_edge: assert property (warm_reset |-> $past(din[3]) != $past(din[3], 4))
      else $error("warm reset without input edge");
   chk_step_mute: assert property (home_creep && $past(home_creep) |-> !step_out)
      else $error("step passed during stored move");
endmodule

bind dmt_core dmt_checker chk (.sys_clk(sys_clk), .rst_n(rst_n), .din(din),
   .motion_cmd(motion_cmd), .motion_rate(motion_rate), .jog_run(jog_run),
   .move_start(move_start), .move_num(move_num), .home_creep(home_creep),
   .home_offset(home_offset), .home_dir(home_dir), .zero_pos(zero_pos),
   .step_out(step_out), .warm_reset(warm_reset));

`default_nettype wire

// >>> bench/dmt_engine_model.sv
// Behavioural profile engine facing the move trigger block.
// Assumes the command codes of the block; slow stretches each move.
`timescale 1ns/1ns
`default_nettype none

module dmt_engine_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic [1:0] motion_cmd,
   input wire logic move_start,
   output logic engine_busy,
   output logic engine_stopped,
   output logic move_done
);
   logic [7:0] left;

   // A kill drops motion at once; a launch runs a short or long move.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         left <= 8'h00;
         engine_busy <= 1'b0;
         move_done <= 1'b0;
      end else begin
         move_done <= 1'b0;
         if (motion_cmd == 2'h2) begin
            left <= 8'h00;
            engine_busy <= 1'b0;
         end else if (move_start) begin
            left <= slow ? 8'h28 : 8'h03;
            engine_busy <= 1'b1;
         end else if (engine_busy) begin
            left <= left - 8'h01;
            if (left == 8'h01) begin
               engine_busy <= 1'b0;
               move_done <= 1'b1;
            end
         end
      end
   end

   // Rest is simply the absence of motion in this model.
   assign engine_stopped = !engine_busy;
endmodule

`default_nettype wire

// >>> bench/tb_discrete_io_move_trigger.sv
// Self-checking bench for the discrete input and move trigger block.
// Assumes the core, its header and the engine model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "dmt_defs.vh"

`define DMT_CMP(got, exp) begin \
   checked++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp); \
   end \
end

module tb_discrete_io_move_trigger;
   logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, dout, slow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed, r, e, f;
   logic [3:0] din;
   logic step_in, dir_in, fault, stall, busy, stopped, done, jog_run;
   logic [1:0] motion_cmd;
   logic [2:0] move_num;
   logic move_start, warm_reset;
   logic [31:0] rq[$];
   logic [31:0] ev[$];
   int bad_count, checked, n, i;

   dmt_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .din(din), .dout(dout), .step_in(step_in), .dir_in(dir_in),
      .fault(fault), .stall_open_loop_stall_estimator(stall), .engine_busy(busy),
      .engine_stopped(stopped), .move_done(done), .motion_cmd(motion_cmd),
      .motion_rate(), .jog_run(jog_run), .jog_dir(), .jog_high(), .move_start(move_start),
      .move_num(move_num), .home_creep(), .home_offset(), .home_dir(), .zero_pos(),
      .step_out(), .dir_out(), .warm_reset(warm_reset));

   dmt_engine_model eng (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
      .motion_cmd(motion_cmd), .move_start(move_start), .engine_busy(busy),
      .engine_stopped(stopped), .move_done(done));

   // ----------------------------------------------------------------
   // Clock, random source and bus tasks
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // The request is held until pready is seen, whatever the latency.
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge keeps a following call from reassigning psel now.
      @(posedge sys_clk);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] x);
      rq.push_back(x);
      apb(1'b0, a, 32'h0);
   endtask

   task wait_done();
      for (i = 0; i < 400 && done !== 1'b1; i++) @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
   endtask

   task stop_test();
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Monitor: each read or launch takes the oldest note off its queue.
   always @(posedge sys_clk) begin
      if (psel && penable && pready && !pwrite) begin
         e = rq.pop_front();
         `DMT_CMP(prdata, e)
      end
      // A warm reset carries no move number; move_num keeps the last launch.
      if (move_start || warm_reset) begin
         e = {28'h0, warm_reset, (warm_reset ? 3'h0 : move_num)};
         f = ev.pop_front();
         `DMT_CMP(e, f)
      end
   end

   // Watchdog sized well above the warm boot hold and the move loop.
   initial begin
      repeat (90000) @(posedge sys_clk);
      bad_count++;
      stop_test();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, din, slow} = '0;
      {step_in, dir_in, fault, stall} = 4'h0;
      seed = 32'hC080C256;
      rst_n = 1'b0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rd(`DMT_OFS_POL, 32'hF);
      rd(12'h020, 32'h0);
      apb(1'b1, `DMT_OFS_SCAN, 32'hFFFF);
      rd(`DMT_OFS_SCAN, 32'h4CC8);
      apb(1'b1, `DMT_OFS_SCAN, 32'h0);
      apb(1'b1, `DMT_OFS_FUNC, {23'h0, `DMT_FN_MSEL, `DMT_FN_MSEL, `DMT_FN_MSEL});
      $display("test registers done");
      for (n = 1; n < 8; n++) begin
         r = rnd();
         slow <= r[0];
         din <= {r[1], n[2:0]};
         ev.push_back({29'h0, n[2:0]});
         wait_done();
         din <= {r[2], 3'h0};
         repeat (4) @(posedge sys_clk);
      end
      $display("test move codes done");
      apb(1'b1, `DMT_OFS_FUNC, {23'h0, `DMT_FN_NONE, `DMT_FN_MSEL, `DMT_FN_LIMIT});
      ev.push_back(32'h2);
      apb(1'b1, `DMT_OFS_POL, 32'hD);
      wait_done();
      din <= 4'h2;
      repeat (4) @(posedge sys_clk);
      $display("test fixed weight done");
      apb(1'b1, `DMT_OFS_FUNC, {23'h0, `DMT_FN_JOGP, `DMT_FN_NONE, `DMT_FN_NONE});
      apb(1'b1, `DMT_OFS_POL, 32'hF);
      din <= 4'h4;
      repeat (4) @(posedge sys_clk);
      `DMT_CMP(jog_run, 1'b1)
      apb(1'b1, `DMT_OFS_FUNC, {23'h0, `DMT_FN_STOP, `DMT_FN_NONE, `DMT_FN_NONE});
      repeat (4) @(posedge sys_clk);
      `DMT_CMP(motion_cmd, 2'h1)
      apb(1'b1, `DMT_OFS_FUNC, {23'h0, `DMT_FN_KILL, `DMT_FN_NONE, `DMT_FN_NONE});
      repeat (4) @(posedge sys_clk);
      `DMT_CMP(motion_cmd, 2'h2)
      din <= 4'h0;
      apb(1'b1, `DMT_OFS_FUNC, 32'h1 << `DMT_FUNC_WB_BIT);
      din <= 4'h8;
      repeat (50000) @(posedge sys_clk);
      ev.push_back(32'h8);
      din <= 4'h0;
      repeat (10) @(posedge sys_clk);
      $display("test warm boot done");
      apb(1'b1, `DMT_OFS_OUTCFG, 32'h5);
      fault <= 1'b1;
      repeat (4) @(posedge sys_clk);
      `DMT_CMP(dout, 1'b1)
      fault <= 1'b0;
      repeat (4) @(posedge sys_clk);
      `DMT_CMP(dout, 1'b0)
      `DMT_CMP(ev.size(), 0)
      $display("test brake done");
      stop_test();
   end
endmodule

`default_nettype wire
